// ==== core/sfds_pkg.sv ====
// Constants, field layouts and phase codes of the squib FET diagnostic
// sequencer. Shared by both ends of the register link.
package sfds_pkg;
  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_SYS_DIAG_REQ  = 6'h36;
  localparam logic [5:0] ADDR_LOOP_DIAG_STS = 6'h37;
  localparam logic [5:0] ADDR_LOOP_DIAG_REQ = 6'h38;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  localparam int REQ_HL_BIT    = 15;
  localparam int REQ_FUNC_LSB  = 5;
  localparam int REQ_SIDE_BIT  = 4;
  localparam int STS_HL_BIT    = 19;
  localparam int STS_RUN_BIT   = 18;
  localparam int STS_FETON_BIT = 15;
  localparam int STS_FUNC_LSB  = 8;
  localparam int STS_LOOPS_BIT = 7;
  localparam int STS_STG_BIT   = 6;
  localparam int STS_STB_BIT   = 5;
  localparam int STS_SIDE_BIT  = 4;
  localparam int REG_W         = 16;
  localparam int STS_W         = 20;
  localparam int NCH           = 4;

  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]  FUNC_FET_TEST = 3'h7;
  localparam logic [3:0]  DRV_TEST_HS   = 4'h7;
  localparam logic [3:0]  DRV_TEST_LS   = 4'h8;
  localparam logic [19:0] STS_RESET     = 20'h00000;
  localparam logic [1:0]  PHASE_INIT    = 2'h0;
  localparam logic [1:0]  PHASE_DIAG    = 2'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int FET_TIMEOUT_US   = 200;
  localparam int FET_TIMEOUT_CYC  = FET_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
endpackage

// ==== core/sfds_link_if.sv ====
// Word-level register link between host controller and diagnostic device.
// Assumes one clock shared by both ends; the bench instantiates it.
`timescale 1ns/1ns
`default_nettype none
interface sfds_link_if;
  logic        req_wr;
  logic        req_rd;
  logic [5:0]  req_addr;
  logic [15:0] req_wdata;
  logic        rsp_valid;
  logic [19:0] rsp_rdata;

  modport host (output req_wr, req_rd, req_addr, req_wdata,
                input  rsp_valid, rsp_rdata);
  modport dev  (input  req_wr, req_rd, req_addr, req_wdata,
                output rsp_valid, rsp_rdata);
endinterface
`default_nettype wire

// ==== core/sfds_dev_end.sv ====
// Device end: register file and FET test sequencer for four squib loops.
// Assumes analog checkers and current comparators on core_clk_i.
//
// What this block does
// - End test, FET off after 200 us timeout.
// - Switch off at once on current threshold.
// - Validate reference, check leakage, then switch FET.
// - Loop request: bit15, function 111, side, channel.
// - System request code 1000 starts low-side test.
// - Status bit15 FET on, function 0111.
// - Bit19 diag requested, bit18 while running.
// - Status bits 7..0: shorts, side, channel.
// - Host: high-side passes on battery-only flag.
// - Host: low-side passes on ground-only flag.
// - Flags latched, cleared by new request.
// - Low-side FET grounds return pin, monitored.
// - No loop writes in INIT; system only DIAG.
// - Code 0111 high-side test, feed side.
`timescale 1ns/1ns
`default_nettype none
module sfds_dev_end #(
  parameter int TIMEOUT_CYC = sfds_pkg::FET_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // Register link
  sfds_link_if.dev        link,
  // Operating phase of the device
  input  wire logic [1:0] op_phase_i,
  // Reference and leakage checks
  input  wire logic       chk_done_i,
  input  wire logic       chk_pass_i,
  output logic            cmref_chk_o,
  output logic            leak_chk_o,
  // Current comparators and short sensing
  input  wire logic       hs_over_i,
  input  wire logic       ls_over_i,
  input  wire logic       gnd_sense_i,
  input  wire logic       bat_sense_i,
  input  wire logic       loop_short_i,
  // FET drives
  output logic [3:0]      hs_fet_on_o,
  output logic [3:0]      ls_fet_on_o
);
  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SFDS_IDLE = 4'b0001,
    SFDS_CREF = 4'b0010,
    SFDS_LEAK = 4'b0100,
    SFDS_FET  = 4'b1000
  } sfds_dev_state_t;

  sfds_dev_state_t state_r, state_nxt;
  logic [15:0]     loop_req_r, loop_req_nxt;
  logic            hs_sel_r, hs_sel_nxt;
  logic [14:0]     tmo_r, tmo_nxt;
  logic            hl_r, hl_nxt;
  logic            feton_r, feton_nxt;
  logic            stg_r, stg_nxt;
  logic            stb_r, stb_nxt;
  logic            short_r, short_nxt;
  logic            rvld_r, rvld_nxt;
  logic [19:0]     rdata_r, rdata_nxt;
  logic [3:0]      hs_r, hs_nxt;
  logic [3:0]      ls_r, ls_nxt;
  logic            cref_r, cref_nxt;
  logic            leak_r, leak_nxt;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  logic wr_loop;
  logic wr_sys;
  logic sys_hs;
  logic sys_ls;
  logic fet_req;
  logic over;
  logic [19:0] status;

  // Accepted writes by phase
  assign wr_loop = link.req_wr && link.req_addr == sfds_pkg::ADDR_LOOP_DIAG_REQ
                   && op_phase_i != sfds_pkg::PHASE_INIT;
  assign wr_sys  = link.req_wr && link.req_addr == sfds_pkg::ADDR_SYS_DIAG_REQ
                   && op_phase_i == sfds_pkg::PHASE_DIAG;
  assign sys_hs  = link.req_wdata[3:0] == sfds_pkg::DRV_TEST_HS;
  assign sys_ls  = link.req_wdata[3:0] == sfds_pkg::DRV_TEST_LS;
  // Latched loop request must name a high level FET test
  assign fet_req = loop_req_r[sfds_pkg::REQ_HL_BIT]
                   && loop_req_r[sfds_pkg::REQ_FUNC_LSB +: 3]
                      == sfds_pkg::FUNC_FET_TEST;
  // Comparator of the selected side
  assign over    = hs_sel_r ? hs_over_i : ls_over_i;

  // Status word assembly
  always_comb begin
    status = sfds_pkg::STS_RESET;
    status[sfds_pkg::STS_HL_BIT]    = hl_r;
    status[sfds_pkg::STS_RUN_BIT]   = state_r != SFDS_IDLE;
    status[sfds_pkg::STS_FETON_BIT] = feton_r;
    status[sfds_pkg::STS_FUNC_LSB +: 4] =
      {1'b0, loop_req_r[sfds_pkg::REQ_FUNC_LSB +: 3]};
    status[sfds_pkg::STS_LOOPS_BIT] = short_r;
    status[sfds_pkg::STS_STG_BIT]   = stg_r;
    status[sfds_pkg::STS_STB_BIT]   = stb_r;
    status[sfds_pkg::STS_SIDE_BIT]  = loop_req_r[sfds_pkg::REQ_SIDE_BIT];
    status[3:0]                     = loop_req_r[3:0];
  end

  // ----------------------------------------------------------------------
  // Register file and read port
  // ----------------------------------------------------------------------
  // Next values for stored request and read answer
  always_comb begin
    loop_req_nxt = loop_req_r;
    rvld_nxt     = link.req_rd;
    rdata_nxt    = 20'h00000;
    if (wr_loop) begin
      loop_req_nxt = link.req_wdata;
    end
    if (link.req_rd && link.req_addr == sfds_pkg::ADDR_LOOP_DIAG_STS) begin
      rdata_nxt = status;
    end
  end

  // Register file flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loop_req_r <= 16'h0000;
      rvld_r     <= 1'b0;
      rdata_r    <= 20'h00000;
    end else begin
      loop_req_r <= loop_req_nxt;
      rvld_r     <= rvld_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign link.rsp_valid = rvld_r;
  assign link.rsp_rdata = rdata_r;

  // ----------------------------------------------------------------------
  // Test sequencer
  // ----------------------------------------------------------------------
  // Next state, FET drive and result flags
  always_comb begin
    state_nxt = state_r;
    hs_sel_nxt = hs_sel_r;
    tmo_nxt   = tmo_r;
    hl_nxt    = hl_r;
    feton_nxt = feton_r;
    stg_nxt   = stg_r;
    stb_nxt   = stb_r;
    short_nxt = short_r;
    hs_nxt    = 4'h0;
    ls_nxt    = 4'h0;
    cref_nxt  = 1'b0;
    leak_nxt  = 1'b0;
    // A new request clears the latched results
    if (wr_loop || wr_sys) begin
      stg_nxt   = 1'b0;
      stb_nxt   = 1'b0;
      short_nxt = 1'b0;
      feton_nxt = 1'b0;
    end
    if (wr_loop) begin
      hl_nxt = link.req_wdata[sfds_pkg::REQ_HL_BIT];
    end
    case (state_r)
      SFDS_IDLE: begin
        if (wr_sys && fet_req && (sys_hs || sys_ls)) begin
          hs_sel_nxt = sys_hs;
          state_nxt  = SFDS_CREF;
          cref_nxt   = 1'b1;
        end
      end
      SFDS_CREF: begin
        cref_nxt = !chk_done_i;
        if (chk_done_i) begin
          state_nxt = chk_pass_i ? SFDS_LEAK : SFDS_IDLE;
          leak_nxt  = chk_pass_i;
        end
      end
      SFDS_LEAK: begin
        leak_nxt = !chk_done_i;
        if (chk_done_i && !chk_pass_i) begin
          state_nxt = SFDS_IDLE;
        end else if (chk_done_i) begin
          state_nxt = SFDS_FET;
          tmo_nxt   = 15'(TIMEOUT_CYC - 1);
          feton_nxt = 1'b1;
          hs_nxt[loop_req_r[1:0]] = hs_sel_r;
          ls_nxt[loop_req_r[1:0]] = !hs_sel_r;
        end
      end
      SFDS_FET: begin
        if (over || tmo_r == 15'h0000) begin
          state_nxt = SFDS_IDLE;
          short_nxt = loop_short_i;
          if (hs_sel_r) begin
            stb_nxt = over;
            stg_nxt = gnd_sense_i;
          end else begin
            stg_nxt = over;
            stb_nxt = bat_sense_i;
          end
        end else begin
          tmo_nxt = tmo_r - 15'h0001;
          hs_nxt  = hs_r;
          ls_nxt  = ls_r;
        end
      end
      default: begin
        state_nxt = SFDS_IDLE;
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r  <= SFDS_IDLE;
      hs_sel_r <= 1'b0;
      tmo_r    <= 15'h0000;
      hl_r     <= 1'b0;
      feton_r  <= 1'b0;
      stg_r    <= 1'b0;
      stb_r    <= 1'b0;
      short_r  <= 1'b0;
      hs_r     <= 4'h0;
      ls_r     <= 4'h0;
      cref_r   <= 1'b0;
      leak_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      hs_sel_r <= hs_sel_nxt;
      tmo_r    <= tmo_nxt;
      hl_r     <= hl_nxt;
      feton_r  <= feton_nxt;
      stg_r    <= stg_nxt;
      stb_r    <= stb_nxt;
      short_r  <= short_nxt;
      hs_r     <= hs_nxt;
      ls_r     <= ls_nxt;
      cref_r   <= cref_nxt;
      leak_r   <= leak_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hs_fet_on_o = hs_r;
  assign ls_fet_on_o = ls_r;
  assign cmref_chk_o = cref_r;
  assign leak_chk_o  = leak_r;
endmodule
`default_nettype wire

// ==== core/sfds_host_end.sv ====
// Host end: issues a FET test, polls status, judges the result.
// Assumes the device end on the same clock across sfds_link_if.
`timescale 1ns/1ns
`default_nettype none
module sfds_host_end (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // Register link
  sfds_link_if.host       link,
  // User request
  input  wire logic       start_i,
  input  wire logic       high_side_i,
  input  wire logic [1:0] channel_i,
  input  wire logic       diag_phase_i,
  // User result
  output logic            busy_o,
  output logic            done_o,
  output logic            pass_o,
  output logic [19:0]     status_o
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SFDS_H_IDLE = 4'b0001,
    SFDS_H_SYS  = 4'b0010,
    SFDS_H_POLL = 4'b0100,
    SFDS_H_WAIT = 4'b1000
  } sfds_host_state_t;

  sfds_host_state_t state_r, state_nxt;
  logic        hs_r, hs_nxt;
  logic        wr_r, wr_nxt;
  logic        rd_r, rd_nxt;
  logic [5:0]  addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic        done_r, done_nxt;
  logic        pass_r, pass_nxt;
  logic [19:0] sts_r, sts_nxt;
  logic        short_to_ground_flag;
  logic        stb;

  assign short_to_ground_flag = link.rsp_rdata[sfds_pkg::STS_STG_BIT];
  assign stb = link.rsp_rdata[sfds_pkg::STS_STB_BIT];

  // Request sequence and verdict
  always_comb begin
    state_nxt = state_r;
    hs_nxt    = hs_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    done_nxt  = 1'b0;
    pass_nxt  = pass_r;
    sts_nxt   = sts_r;
    case (state_r)
      SFDS_H_IDLE: begin
        if (start_i && diag_phase_i) begin
          hs_nxt    = high_side_i;
          wr_nxt    = 1'b1;
          addr_nxt  = sfds_pkg::ADDR_LOOP_DIAG_REQ;
          wdata_nxt = {1'b1, 7'h00, sfds_pkg::FUNC_FET_TEST,
                       high_side_i, 2'h0, channel_i};
          state_nxt = SFDS_H_SYS;
        end
      end
      SFDS_H_SYS: begin
        wr_nxt    = 1'b1;
        addr_nxt  = sfds_pkg::ADDR_SYS_DIAG_REQ;
        wdata_nxt = {12'h000, hs_r ? sfds_pkg::DRV_TEST_HS
                                   : sfds_pkg::DRV_TEST_LS};
        state_nxt = SFDS_H_POLL;
      end
      SFDS_H_POLL: begin
        rd_nxt    = 1'b1;
        addr_nxt  = sfds_pkg::ADDR_LOOP_DIAG_STS;
        state_nxt = SFDS_H_WAIT;
      end
      SFDS_H_WAIT: begin
        if (link.rsp_valid) begin
          sts_nxt = link.rsp_rdata;
          if (link.rsp_rdata[sfds_pkg::STS_RUN_BIT]) begin
            state_nxt = SFDS_H_POLL;
          end else begin
            done_nxt  = 1'b1;
            pass_nxt  = hs_r ? (stb && !short_to_ground_flag)
                             : (short_to_ground_flag && !stb);
            state_nxt = SFDS_H_IDLE;
          end
        end
      end
      default: begin
        state_nxt = SFDS_H_IDLE;
      end
    endcase
  end

  // Host flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= SFDS_H_IDLE;
      hs_r    <= 1'b0;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      addr_r  <= 6'h00;
      wdata_r <= 16'h0000;
      done_r  <= 1'b0;
      pass_r  <= 1'b0;
      sts_r   <= 20'h00000;
    end else begin
      state_r <= state_nxt;
      hs_r    <= hs_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r  <= done_nxt;
      pass_r  <= pass_nxt;
      sts_r   <= sts_nxt;
    end
  end

  // Outputs from flops
  assign link.req_wr    = wr_r;
  assign link.req_rd    = rd_r;
  assign link.req_addr  = addr_r;
  assign link.req_wdata = wdata_r;
  assign busy_o         = state_r != SFDS_H_IDLE;
  assign done_o         = done_r;
  assign pass_o         = pass_r;
  assign status_o       = sts_r;
endmodule
`default_nettype wire

// ==== dv/sfds_link_asserts.sv ====
// Link checker: timing and status-field relations on the host link.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ns
`default_nettype none
module sfds_link_asserts (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  // Link signals
  input wire logic        req_wr,
  input wire logic        req_rd,
  input wire logic [5:0]  req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        rsp_valid,
  input wire logic [19:0] rsp_rdata
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  logic       sts_rd_r;
  logic       sts_rd_nxt;
  logic       flg_ok_r;
  logic       flg_ok_nxt;
  logic [1:0] flg_r;
  logic [1:0] flg_nxt;
  logic       lreq;
  logic       sreq;

  // Decoded write requests
  assign lreq = req_wr && (req_addr == sfds_pkg::ADDR_LOOP_DIAG_REQ);
  assign sreq = req_wr && (req_addr == sfds_pkg::ADDR_SYS_DIAG_REQ);

  // Flags last read back, kept until the next write
  always_comb begin
    sts_rd_nxt = req_rd && (req_addr == sfds_pkg::ADDR_LOOP_DIAG_STS);
    flg_ok_nxt = flg_ok_r && !req_wr;
    flg_nxt    = flg_r;
    if (sts_rd_r && rsp_valid) begin
      flg_ok_nxt = !req_wr;
      flg_nxt    = rsp_rdata[6:5];
    end
  end

  // Registers of the helper state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sts_rd_r <= 1'b0;
      flg_ok_r <= 1'b0;
      flg_r    <= 2'h0;
    end else begin
      sts_rd_r <= sts_rd_nxt;
      flg_ok_r <= flg_ok_nxt;
      flg_r    <= flg_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_read_answer: assert property (req_rd |=> rsp_valid)
    else $error("read not answered in the next cycle");
  a_answer_cause: assert property (rsp_valid |-> $past(req_rd))
    else $error("answer without a read");
  a_wo_read_zero: assert property (req_rd && !sts_rd_nxt |=>
    rsp_rdata == 20'h00000) else $error("write-only read not zero");
  a_running_fields: assert property (rsp_valid && rsp_rdata[18] |->
    rsp_rdata[19] && rsp_rdata[11:8] == 4'h7)
    else $error("running status fields wrong");
  // Reference and leak steps run before the FET is on, so bit 15 is only
  // required once a result flag shows that the FET phase was reached
  a_fet_on_mark: assert property (rsp_valid && (|rsp_rdata[6:5]) |->
    rsp_rdata[15]) else $error("result flags without FET-on mark");
  a_status_fixed: assert property (rsp_valid |->
    rsp_rdata[17:16] == 2'h0 && rsp_rdata[3:2] == 2'h0)
    else $error("status fixed bits wrong");
  a_loop_req_form: assert property (lreq |-> req_wdata[15] &&
    req_wdata[7:5] == sfds_pkg::FUNC_FET_TEST && req_wdata[3:2] == 2'h0)
    else $error("loop request format wrong");
  a_hs_code: assert property (lreq && req_wdata[4] |=>
    sreq && req_wdata[3:0] == sfds_pkg::DRV_TEST_HS)
    else $error("high-side code not sent after loop request");
  a_ls_code: assert property (lreq && !req_wdata[4] |=>
    sreq && req_wdata[3:0] == sfds_pkg::DRV_TEST_LS)
    else $error("low-side code not sent after loop request");
  a_flags_latched: assert property (sts_rd_r && rsp_valid && flg_ok_r |->
    (rsp_rdata[6:5] & flg_r) == flg_r)
    else $error("result flag dropped without a write");

  // Main scenarios reached
  c_hs_start: cover property (sreq && req_wdata[3:0] == sfds_pkg::DRV_TEST_HS);
  c_running: cover property (rsp_valid && rsp_rdata[18]);
  c_flag_set: cover property (rsp_valid && (|rsp_rdata[6:5]));
endmodule
`default_nettype wire

// ==== dv/squib_fet_diag_sequencer_tb.sv ====
// Bench: host end and device end face each other on one link; a second
// device end sits on a link driven by the bench itself.
// Assumes the package, link, both ends and the checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module squib_fet_diag_sequencer_tb;
  localparam int TMO = 20;
  localparam logic [5:0] LQ = sfds_pkg::ADDR_LOOP_DIAG_REQ;
  localparam logic [5:0] SQ = sfds_pkg::ADDR_SYS_DIAG_REQ;
  localparam logic [5:0] ST = sfds_pkg::ADDR_LOOP_DIAG_STS;
  logic        core_clk_i, rstn_i, start_i, high_side_i, diag_phase_i;
  logic [1:0]  channel_i, op_phase_b;
  logic        busy_o, done_o, pass_o, clr_mon;
  logic [19:0] status_o, rd;
  logic        chk_pass, over_en, gnd_sense, bat_sense, loop_short;
  logic        done_a, done_b, hs_ov_a, ls_ov_a, hs_ov_b, ls_ov_b;
  logic        cmref_a, leak_a, cmref_b, leak_b;
  logic [3:0]  hs_a, ls_a, hs_b, ls_b, hs_seen, ls_seen, b_seen;
  int          errors, cmp_count, fet_cyc;

  sfds_link_if u_sfds_link_if ();
  sfds_link_if u_sfds_link_if_b ();
  sfds_host_end u_sfds_host_end (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .link(u_sfds_link_if), .start_i(start_i), .high_side_i(high_side_i),
    .channel_i(channel_i), .diag_phase_i(diag_phase_i), .busy_o(busy_o),
    .done_o(done_o), .pass_o(pass_o), .status_o(status_o));
  sfds_dev_end #(.TIMEOUT_CYC(TMO)) u_sfds_dev_end (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .link(u_sfds_link_if), .chk_done_i(done_a),
    .op_phase_i(sfds_pkg::PHASE_DIAG), .chk_pass_i(chk_pass),
    .cmref_chk_o(cmref_a), .leak_chk_o(leak_a), .hs_over_i(hs_ov_a),
    .ls_over_i(ls_ov_a), .gnd_sense_i(gnd_sense), .bat_sense_i(bat_sense),
    .loop_short_i(loop_short), .hs_fet_on_o(hs_a), .ls_fet_on_o(ls_a));
  sfds_dev_end #(.TIMEOUT_CYC(TMO)) u_sfds_dev_end_b (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(u_sfds_link_if_b),
    .op_phase_i(op_phase_b), .chk_done_i(done_b), .chk_pass_i(chk_pass),
    .cmref_chk_o(cmref_b), .leak_chk_o(leak_b), .hs_over_i(hs_ov_b),
    .ls_over_i(ls_ov_b), .gnd_sense_i(gnd_sense), .bat_sense_i(bat_sense),
    .loop_short_i(loop_short), .hs_fet_on_o(hs_b), .ls_fet_on_o(ls_b));
  sfds_link_asserts u_sfds_link_asserts (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .req_wr(u_sfds_link_if.req_wr),
    .req_rd(u_sfds_link_if.req_rd), .req_addr(u_sfds_link_if.req_addr),
    .req_wdata(u_sfds_link_if.req_wdata),
    .rsp_valid(u_sfds_link_if.rsp_valid),
    .rsp_rdata(u_sfds_link_if.rsp_rdata));

  // Clock of 10 ns
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Check acks, comparators and a record of FET activity
  always @(posedge core_clk_i) begin
    done_a  <= cmref_a | leak_a;
    done_b  <= cmref_b | leak_b;
    hs_ov_a <= over_en && (|hs_a);
    ls_ov_a <= over_en && (|ls_a);
    hs_ov_b <= over_en && (|hs_b);
    ls_ov_b <= over_en && (|ls_b);
    b_seen  <= b_seen | hs_b | ls_b;
    fet_cyc <= clr_mon ? 0 : fet_cyc + int'((|hs_a) || (|ls_a));
    hs_seen <= clr_mon ? 4'h0 : hs_seen | hs_a;
    ls_seen <= clr_mon ? 4'h0 : ls_seen | ls_a;
  end

  task automatic check(input string what, input logic [19:0] exp,
                       input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One FET test through the host end, judged from the rules
  task automatic host_test(input logic hs, input logic [1:0] ch,
                           input logic ovr, ok, gnd, bat);
    logic       short_to_ground_flag, stb;
    logic [3:0] m;
    int         n;
    short_to_ground_flag = hs ? gnd : ovr;
    stb = hs ? ovr : bat;
    m = 4'h1 << ch;
    @(posedge core_clk_i);
    chk_pass <= ok;
    over_en <= ovr;
    gnd_sense <= gnd;
    bat_sense <= bat;
    high_side_i <= hs;
    channel_i <= ch;
    start_i <= 1'b1;
    clr_mon <= 1'b1;
    @(posedge core_clk_i);
    start_i <= 1'b0;
    clr_mon <= 1'b0;
    #1;
    check("busy", 20'h1, 20'(busy_o));
    n = 0;
    while (done_o !== 1'b1 && n < 3000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (done_o !== 1'b1) begin
      errors++;
      give_verdict();
    end
    check("idle", 20'h0, 20'(busy_o));
    if (ok) begin
      check("status", {1'b1, 3'h0, 1'b1, 3'h0, 1'b0, sfds_pkg::FUNC_FET_TEST,
        1'b0, short_to_ground_flag, stb, hs, 2'h0, ch}, status_o);
      check("pass", 20'(hs ? stb && !short_to_ground_flag : short_to_ground_flag && !stb), 20'(pass_o));
      check("fet", {12'h0, hs ? m : 4'h0, hs ? 4'h0 : m},
        {12'h0, hs_seen, ls_seen});
      if (ovr) check("quick_off", 20'h1, 20'(fet_cyc < TMO));
      else check("on_cycles", 20'(TMO), 20'(fet_cyc));
    end else begin
      check("no_fet", 20'h0, {12'h0, hs_seen, ls_seen});
      check("flags", 20'h0, status_o & 20'h08060);
      check("pass", 20'h0, 20'(pass_o));
    end
  endtask

  // Bus cycles on the bench-driven link
  task automatic link_wr(input logic [5:0] a, input logic [15:0] d);
    u_sfds_link_if_b.req_wr <= 1'b1;
    u_sfds_link_if_b.req_addr <= a;
    u_sfds_link_if_b.req_wdata <= d;
    @(posedge core_clk_i);
    u_sfds_link_if_b.req_wr <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic link_rd(input logic [5:0] a);
    u_sfds_link_if_b.req_rd <= 1'b1;
    u_sfds_link_if_b.req_addr <= a;
    @(posedge core_clk_i);
    u_sfds_link_if_b.req_rd <= 1'b0;
    #1;
    rd = u_sfds_link_if_b.rsp_valid ? u_sfds_link_if_b.rsp_rdata : 20'hFFFFF;
    @(posedge core_clk_i);
  endtask

  // Main sequence
  initial begin
    {rstn_i, start_i, high_side_i, channel_i, over_en} = '0;
    {gnd_sense, bat_sense, loop_short, clr_mon, fet_cyc} = '0;
    {done_a, done_b, hs_ov_a, ls_ov_a, hs_ov_b, ls_ov_b} = '0;
    {hs_seen, ls_seen, b_seen, errors, cmp_count} = '0;
    {u_sfds_link_if_b.req_wr, u_sfds_link_if_b.req_rd} = '0;
    {u_sfds_link_if_b.req_addr, u_sfds_link_if_b.req_wdata} = '0;
    diag_phase_i = 1'b1;
    chk_pass = 1'b1;
    op_phase_b = sfds_pkg::PHASE_INIT;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    host_test(1'b1, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    host_test(1'b0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b0);
    host_test(1'b0, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
    host_test(1'b1, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0);
    host_test(1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge core_clk_i);
    over_en <= 1'b1;
    chk_pass <= 1'b1;
    bat_sense <= 1'b0;
    link_wr(LQ, 16'h80E0);
    op_phase_b <= sfds_pkg::PHASE_DIAG;
    link_wr(SQ, 16'h0008);
    repeat (TMO + 10) @(posedge core_clk_i);
    link_rd(ST);
    check("init_write", 20'h0, rd);
    link_wr(LQ, 16'h80E0);
    link_wr(SQ, 16'h0005);
    op_phase_b <= 2'h2;
    link_wr(SQ, 16'h0008);
    repeat (TMO + 10) @(posedge core_clk_i);
    check("refused", 20'h0, {16'h0, b_seen});
    op_phase_b <= sfds_pkg::PHASE_DIAG;
    loop_short <= 1'b1;
    link_wr(SQ, 16'h0008);
    repeat (TMO + 10) @(posedge core_clk_i);
    link_rd(ST);
    check("ls_status", 20'h887C0, rd);
    check("ls_fet", 20'h1, {16'h0, b_seen});
    repeat (5) @(posedge core_clk_i);
    link_rd(ST);
    check("latched", 20'h887C0, rd);
    link_rd(SQ);
    check("wo_read", 20'h0, rd);
    link_rd(6'h3F);
    check("unmapped", 20'h0, rd);
    link_wr(LQ, 16'h8060);
    link_rd(ST);
    check("cleared", 20'h0, rd & 20'h080E0);
    give_verdict();
  end
endmodule
`default_nettype wire
